// >>> hw/iak_regs.svh
// constants for the interrupt acknowledge block
`ifndef IAK_REGS_SVH
`define IAK_REGS_SVH
`define IAK_NSRC 13
`define IAK_PSW_RST 8'h02
`define IAK_IE_BIT 7
`define IAK_ISP_BIT 1
`define IAK_MSK_RST 13'h1fff
`define IAK_PRI_RST 13'h1fff
`define IAK_REQ_RST 13'h0000
`define IAK_EXT0_SRC 1
`define IAK_SMP_DIV 8'h07
`define IAK_VEC_NMI 16'h0004
`define IAK_VEC_BRK 16'h003e
`define IAK_VEC_BASE 16'h0006
`endif

// >>> hw/iak_pkg.sv
// types for the interrupt acknowledge block
package iak_pkg;
    typedef enum logic [3:0] {
        IAK_OP_NOP = 4'h0,
        IAK_OP_EI = 4'h1,
        IAK_OP_DI = 4'h2,
        IAK_OP_PSW_WR = 4'h3,
        IAK_OP_PSW_SET = 4'h4,
        IAK_OP_PSW_CLR = 4'h5,
        IAK_OP_PUSH_PSW = 4'h6,
        IAK_OP_POP_PSW = 4'h7,
        IAK_OP_IRQ_RETURN_INSTR = 4'h8,
        IAK_OP_BREAK_RETURN_INSTR = 4'h9,
        IAK_OP_BRK = 4'ha,
        IAK_OP_REQ_WR = 4'hb,
        IAK_OP_MSK_WR = 4'hc,
        IAK_OP_PRI_WR = 4'hd
    } iak_op_type;

    typedef struct packed {
        logic valid;
        iak_op_type op;
        logic [15:0] data;
        logic [2:0] bitno;
    } iak_cmd_type;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } iak_push_type;

    typedef enum logic [2:0] {
        IAK_ST_IDLE = 3'h0,
        IAK_ST_WAIT = 3'h1,
        IAK_ST_PSW = 3'h3,
        IAK_ST_PCH = 3'h2,
        IAK_ST_PCL = 3'h6,
        IAK_ST_VEC = 3'h7
    } iak_state_type;

    typedef enum logic [1:0] {
        IAK_K_NMI = 2'h0,
        IAK_K_MASK = 2'h1,
        IAK_K_BRK = 2'h2
    } iak_kind_type;
endpackage

// >>> hw/iak_top.sv
// interrupt acknowledge logic: filter, flags, arbitration, status word, stacking
`timescale 1ns/1ps
`default_nettype none
`include "iak_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module iak_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic boundary_i,
    input var iak_pkg::iak_cmd_type cmd_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] stack_data_i,
    input wire logic nmi_i,
    input wire logic [`IAK_NSRC-1:0] irq_event_i,
    input wire logic ext_irq_input0_i,
    output logic [7:0] processor_status_flags_o,
    output iak_pkg::iak_push_type push_o,
    output logic vector_valid_o,
    output logic [15:0] vector_addr_o,
    output logic busy_o,
    output logic nmi_in_service_o,
    output logic [`IAK_NSRC-1:0] irq_request_flag_o,
    output logic [`IAK_NSRC-1:0] irq_mask_flag_o,
    output logic [`IAK_NSRC-1:0] urgency_select_flag_o
);
    iak_pkg::iak_state_type state;
    iak_pkg::iak_state_type next_state;
    iak_pkg::iak_kind_type kind;
    logic [7:0] smp_cnt;
    logic smp_en;
    logic ext_smp0;
    logic ext_smp1;
    logic ext_lvl;
    logic ext_rise;
    logic nmi_pend;
    logic ret_hold;
    logic [7:0] saved_psw;
    logic [15:0] saved_pc;
    logic [3:0] sel;
    logic [3:0] arb_idx;
    logic arb_found;
    logic arb_hi;
    logic [`IAK_NSRC-1:0] elig;
    logic [`IAK_NSRC-1:0] set_vec;
    logic idle;
    logic cmd_ok;
    logic take;
    logic take_nmi;
    logic take_mask;
    logic take_brk;
    logic global_irq_enable;
    logic in_service_priority;
    localparam logic [`IAK_NSRC-1:0] req_rst = `IAK_REQ_RST;
    localparam logic [`IAK_NSRC-1:0] msk_rst = `IAK_MSK_RST;
    localparam logic [`IAK_NSRC-1:0] pri_rst = `IAK_PRI_RST;

    assign global_irq_enable = processor_status_flags_o[`IAK_IE_BIT];
    assign in_service_priority = processor_status_flags_o[`IAK_ISP_BIT];
    assign idle = (state == iak_pkg::IAK_ST_IDLE);
    assign cmd_ok = cmd_i.valid && idle;

    ////////////////////////////////////////////////////////////////////////////
    // ext0 noise filter
    assign smp_en = (smp_cnt == `IAK_SMP_DIV);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            smp_cnt <= 8'h00;
            ext_smp0 <= 1'b0;
            ext_smp1 <= 1'b0;
            ext_lvl <= 1'b0;
            ext_rise <= 1'b0;
        end else begin
            smp_cnt <= smp_en ? 8'h00 : smp_cnt + 8'h01;
            ext_rise <= 1'b0;
            if (smp_en) begin
                ext_smp0 <= ext_irq_input0_i;
                ext_smp1 <= ext_smp0;
                ext_lvl <= ext_smp0 && ext_smp1;
                ext_rise <= ext_smp0 && ext_smp1 && !ext_lvl;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // arbitration
    always_comb begin
        elig = irq_request_flag_o & ~irq_mask_flag_o;
        arb_found = 1'b0;
        arb_hi = 1'b0;
        arb_idx = 4'h0;
        for (int i = `IAK_NSRC - 1; i >= 0; i--) begin
            if (elig[i] && !arb_hi) begin
                arb_found = 1'b1;
                arb_idx = 4'(i);
            end
        end
        for (int i = `IAK_NSRC - 1; i >= 0; i--) begin
            if (elig[i] && !urgency_select_flag_o[i]) begin
                arb_hi = 1'b1;
                arb_idx = 4'(i);
            end
        end
    end

    // nmi and maskable decisions only at boundaries; break is taken on its command
    assign take = boundary_i && idle && !ret_hold;
    assign take_nmi = take && nmi_pend && !nmi_in_service_o;
    assign take_mask = take && !nmi_pend && !nmi_in_service_o && arb_found
        && global_irq_enable && (arb_hi || in_service_priority);
    assign take_brk = cmd_ok && cmd_i.op == iak_pkg::IAK_OP_BRK && !take_nmi && !take_mask;

    ////////////////////////////////////////////////////////////////////////////
    // non-maskable tracking
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            nmi_pend <= 1'b0;
            nmi_in_service_o <= 1'b0;
            ret_hold <= 1'b0;
        end else begin
            if (nmi_i) begin
                nmi_pend <= 1'b1;
            end else if (take_nmi) begin
                nmi_pend <= 1'b0;
            end
            if (take_nmi) begin
                nmi_in_service_o <= 1'b1;
            end else if (cmd_ok && cmd_i.op == iak_pkg::IAK_OP_IRQ_RETURN_INSTR) begin
                nmi_in_service_o <= 1'b0;
            end
            if (cmd_ok && (cmd_i.op == iak_pkg::IAK_OP_IRQ_RETURN_INSTR
                || cmd_i.op == iak_pkg::IAK_OP_BREAK_RETURN_INSTR)) begin
                ret_hold <= 1'b1;
            end else if (boundary_i) begin
                ret_hold <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // request, mask and urgency flags
    generate
        for (genvar g = 0; g < `IAK_NSRC; g++) begin : g_src
            assign set_vec[g] = irq_event_i[g] || (g == `IAK_EXT0_SRC && ext_rise);
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    irq_request_flag_o[g] <= req_rst[g];
                    irq_mask_flag_o[g] <= msk_rst[g];
                    urgency_select_flag_o[g] <= pri_rst[g];
                end else begin
                    if (set_vec[g]) begin
                        irq_request_flag_o[g] <= 1'b1;
                    end else if (take_mask && arb_idx == 4'(g)) begin
                        irq_request_flag_o[g] <= 1'b0;
                    end else if (cmd_ok && cmd_i.op == iak_pkg::IAK_OP_REQ_WR) begin
                        irq_request_flag_o[g] <= cmd_i.data[g];
                    end
                    if (cmd_ok && cmd_i.op == iak_pkg::IAK_OP_MSK_WR) begin
                        irq_mask_flag_o[g] <= cmd_i.data[g];
                    end
                    if (cmd_ok && cmd_i.op == iak_pkg::IAK_OP_PRI_WR) begin
                        urgency_select_flag_o[g] <= cmd_i.data[g];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // status word
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            processor_status_flags_o <= `IAK_PSW_RST;
        end else if (take_nmi) begin
            processor_status_flags_o[`IAK_IE_BIT] <= 1'b0;
            processor_status_flags_o[`IAK_ISP_BIT] <= 1'b0;
        end else if (take_mask) begin
            processor_status_flags_o[`IAK_IE_BIT] <= 1'b0;
            processor_status_flags_o[`IAK_ISP_BIT] <= urgency_select_flag_o[arb_idx];
        end else if (take_brk) begin
            processor_status_flags_o[`IAK_IE_BIT] <= 1'b0;
        end else if (cmd_ok) begin
            case (cmd_i.op)
                iak_pkg::IAK_OP_EI: processor_status_flags_o[`IAK_IE_BIT] <= 1'b1;
                iak_pkg::IAK_OP_DI: processor_status_flags_o[`IAK_IE_BIT] <= 1'b0;
                iak_pkg::IAK_OP_PSW_WR: processor_status_flags_o <= cmd_i.data[7:0];
                iak_pkg::IAK_OP_PSW_SET: processor_status_flags_o[cmd_i.bitno] <= 1'b1;
                iak_pkg::IAK_OP_PSW_CLR: processor_status_flags_o[cmd_i.bitno] <= 1'b0;
                iak_pkg::IAK_OP_POP_PSW,
                iak_pkg::IAK_OP_IRQ_RETURN_INSTR,
                iak_pkg::IAK_OP_BREAK_RETURN_INSTR: processor_status_flags_o <= stack_data_i;
                default: processor_status_flags_o <= processor_status_flags_o;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // acceptance sequencer
    always_comb begin
        next_state = state;
        case (state)
            iak_pkg::IAK_ST_IDLE: begin
                if (take_mask && !arb_hi) begin
                    next_state = iak_pkg::IAK_ST_WAIT;
                end else if (take_nmi || take_mask || take_brk) begin
                    next_state = iak_pkg::IAK_ST_PSW;
                end
            end
            iak_pkg::IAK_ST_WAIT: next_state = iak_pkg::IAK_ST_PSW;
            iak_pkg::IAK_ST_PSW: next_state = iak_pkg::IAK_ST_PCH;
            iak_pkg::IAK_ST_PCH: next_state = iak_pkg::IAK_ST_PCL;
            iak_pkg::IAK_ST_PCL: next_state = iak_pkg::IAK_ST_VEC;
            iak_pkg::IAK_ST_VEC: next_state = iak_pkg::IAK_ST_IDLE;
            default: next_state = iak_pkg::IAK_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= iak_pkg::IAK_ST_IDLE;
            kind <= iak_pkg::IAK_K_NMI;
            sel <= 4'h0;
            saved_psw <= `IAK_PSW_RST;
            saved_pc <= 16'h0000;
        end else begin
            state <= next_state;
            if (idle && (take_nmi || take_mask || take_brk)) begin
                saved_psw <= processor_status_flags_o;
                saved_pc <= pc_i;
                sel <= arb_idx;
                kind <= take_nmi ? iak_pkg::IAK_K_NMI :
                    (take_mask ? iak_pkg::IAK_K_MASK : iak_pkg::IAK_K_BRK);
            end
        end
    end

    // stack and vector outputs
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            push_o <= '0;
            vector_valid_o <= 1'b0;
            vector_addr_o <= 16'h0000;
            busy_o <= 1'b0;
        end else begin
            busy_o <= (next_state != iak_pkg::IAK_ST_IDLE);
            vector_valid_o <= (state == iak_pkg::IAK_ST_VEC);
            push_o.valid <= 1'b0;
            case (state)
                iak_pkg::IAK_ST_PSW: push_o <= {1'b1, saved_psw};
                iak_pkg::IAK_ST_PCH: push_o <= {1'b1, saved_pc[15:8]};
                iak_pkg::IAK_ST_PCL: push_o <= {1'b1, saved_pc[7:0]};
                default: begin
                    if (cmd_ok && cmd_i.op == iak_pkg::IAK_OP_PUSH_PSW) begin
                        push_o <= {1'b1, processor_status_flags_o};
                    end
                end
            endcase
            if (state == iak_pkg::IAK_ST_VEC) begin
                case (kind)
                    iak_pkg::IAK_K_NMI: vector_addr_o <= `IAK_VEC_NMI;
                    iak_pkg::IAK_K_BRK: vector_addr_o <= `IAK_VEC_BRK;
                    default: vector_addr_o <= `IAK_VEC_BASE + {11'h000, sel, 1'b0};
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_ext_filter: assert property (@(posedge clk_i) disable iff (rst_i)
        ext_rise |=> irq_request_flag_o[`IAK_EXT0_SRC])
        else $error("ext0 flag not set after filtered edge");
    chk_accept_ie: assert property (@(posedge clk_i) disable iff (rst_i)
        (take_nmi || take_mask || take_brk) |=> !global_irq_enable)
        else $error("enable not cleared on acceptance");
    chk_isp_copy: assert property (@(posedge clk_i) disable iff (rst_i)
        take_mask |=> in_service_priority == $past(urgency_select_flag_o[arb_idx]))
        else $error("in-service bit not copied from urgency");
    chk_nmi_stack: assert property (@(posedge clk_i) disable iff (rst_i)
        take_nmi |=> !in_service_priority ##1 push_o.valid && push_o.data == saved_psw
        ##1 push_o.valid ##1 push_o.valid ##1 vector_valid_o)
        else $error("non-maskable stacking sequence wrong");
    chk_nmi_nest: assert property (@(posedge clk_i) disable iff (rst_i)
        nmi_in_service_o |-> !take_nmi && !take_mask)
        else $error("acceptance during non-maskable service");
    chk_mask_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        take_mask |-> global_irq_enable && !irq_mask_flag_o[arb_idx]
        && (in_service_priority || !urgency_select_flag_o[arb_idx]))
        else $error("maskable accepted while not allowed");
    chk_req_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        take_mask && !set_vec[arb_idx] |=> !irq_request_flag_o[$past(arb_idx)])
        else $error("request flag not cleared on acceptance");
    chk_urgent_pick: assert property (@(posedge clk_i) disable iff (rst_i)
        take_mask && |(elig & ~urgency_select_flag_o) |-> !urgency_select_flag_o[arb_idx])
        else $error("low urgency chosen over high");
    chk_low_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        take_mask && !arb_hi |-> ##2 !push_o.valid ##1 push_o.valid ##3 vector_valid_o)
        else $error("low urgency extra cycle missing");
endmodule
`default_nettype wire

// >>> dv/iak_cpu_model.sv
// cpu side stack model for the interrupt acknowledge block
`timescale 1ns/1ps
`default_nettype none
module iak_cpu_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input var iak_pkg::iak_push_type push_i,
    input wire logic pop_i,
    input wire logic frame_i,
    output logic [7:0] stack_data_o
);
    logic [7:0] mem [0:15];
    logic [3:0] sp;
    logic [3:0] top;

    ////////////////////////////////////////////////////////////////////////////
    // stack grows upward; a return frame is status, pc high, pc low
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sp <= 4'h0;
        end else if (push_i.valid) begin
            mem[sp] <= push_i.data;
            sp <= sp + 4'h1;
        end else if (pop_i) begin
            sp <= sp - (frame_i ? 4'h3 : 4'h1);
        end
    end

    assign top = sp - (frame_i ? 4'h3 : 4'h1);
    assign stack_data_o = mem[top];
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the interrupt acknowledge block
`timescale 1ns/1ps
`default_nettype none
`include "iak_regs.svh"
module testbench;
    logic clk_i, rst_i, boundary_i, nmi_i, ext_i, pop, frame, vv, busy, nsrv;
    iak_pkg::iak_cmd_type cmd_i;
    iak_pkg::iak_push_type push_o;
    logic [15:0] pc_i, va;
    logic [7:0] sd, processor_status_flags;
    logic [`IAK_NSRC-1:0] ev, req, msk, pri;
    int n_fail, compares;

    iak_top u_iak_top (.clk_i(clk_i), .rst_i(rst_i), .boundary_i(boundary_i), .cmd_i(cmd_i),
        .pc_i(pc_i), .stack_data_i(sd), .nmi_i(nmi_i), .irq_event_i(ev),
        .ext_irq_input0_i(ext_i), .processor_status_flags_o(processor_status_flags), .push_o(push_o),
        .vector_valid_o(vv), .vector_addr_o(va), .busy_o(busy), .nmi_in_service_o(nsrv),
        .irq_request_flag_o(req), .irq_mask_flag_o(msk), .urgency_select_flag_o(pri));
    iak_cpu_model u_iak_cpu_model (.clk_i(clk_i), .rst_i(rst_i), .push_i(push_o),
        .pop_i(pop), .frame_i(frame), .stack_data_o(sd));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task summarize;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task cps(input logic [7:0] e);
        chk({8'h00, processor_status_flags}, {8'h00, e});
    endtask

    task cq(input logic [15:0] e);
        chk({3'h0, req}, e);
    endtask

    task op(input iak_pkg::iak_op_type o, input logic [15:0] d, input logic [2:0] b);
        @(negedge clk_i);
        cmd_i = {1'b1, o, d, b};
        pop = (o inside {iak_pkg::IAK_OP_IRQ_RETURN_INSTR, iak_pkg::IAK_OP_BREAK_RETURN_INSTR, iak_pkg::IAK_OP_POP_PSW});
        frame = (o != iak_pkg::IAK_OP_POP_PSW);
        @(negedge clk_i);
        cmd_i = '0;
        pop = 1'b0;
    endtask

    task bnd;
        @(negedge clk_i);
        boundary_i = 1'b1;
        @(negedge clk_i);
        boundary_i = 1'b0;
    endtask

    task nmi;
        @(negedge clk_i);
        nmi_i = 1'b1;
        @(negedge clk_i);
        nmi_i = 1'b0;
    endtask

    // lat 0: nothing taken; lat -1: one plain push; else push frame then vector
    task run(input logic [7:0] b0, input logic [15:0] vec, input int lat);
        logic [7:0] got [0:2];
        int n;
        int k1;
        int kv;
        logic bz;
        n = 0;
        k1 = -1;
        kv = -1;
        bz = 1'b0;
        for (int k = 0; k < 10; k++) begin
            if (k == 0) bz = busy;
            if (push_o.valid === 1'b1) begin
                if (n < 3) got[n] = push_o.data;
                if (n == 0) k1 = k;
                n++;
            end
            if (vv === 1'b1 && kv < 0) begin
                kv = k;
                chk(va, vec);
            end
            @(negedge clk_i);
        end
        chk(16'(bz), 16'(lat > 0));
        if (lat == 0) begin
            chk(16'(n + kv + 1), 16'h0000);
        end else if (lat < 0) begin
            chk(16'(n), 16'h0001);
            chk({8'h00, got[0]}, {8'h00, b0});
        end else begin
            chk(16'(n), 16'h0003);
            chk({got[0], got[1]}, {b0, pc_i[15:8]});
            chk({8'h00, got[2]}, {8'h00, pc_i[7:0]});
            chk(16'(kv), 16'(lat - 1));
            chk(16'(k1), 16'(lat - 4));
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_i = 1'b1;
        {boundary_i, nmi_i, ext_i, pop, frame} = 5'h00;
        cmd_i = '0;
        pc_i = 16'h1234;
        ev = '0;
        n_fail = 0;
        compares = 0;
        repeat (16) @(negedge clk_i);
        rst_i = 1'b0;
        cps(8'h02);
        chk({3'h0, msk}, 16'h1fff);
        chk({3'h0, pri}, 16'h1fff);
        cq(16'h0000);
        op(iak_pkg::IAK_OP_EI, 16'h0, 3'h0);
        cps(8'h82);
        op(iak_pkg::IAK_OP_DI, 16'h0, 3'h0);
        cps(8'h02);
        op(iak_pkg::IAK_OP_PSW_WR, 16'h00a5, 3'h0);
        cps(8'ha5);
        op(iak_pkg::IAK_OP_PSW_CLR, 16'h0, 3'h7);
        cps(8'h25);
        op(iak_pkg::IAK_OP_PSW_SET, 16'h0, 3'h6);
        cps(8'h65);
        op(iak_pkg::IAK_OP_PSW_WR, 16'h0082, 3'h0);
        op(iak_pkg::IAK_OP_PUSH_PSW, 16'h0, 3'h0);
        run(8'h82, 16'h0, -1);
        op(iak_pkg::IAK_OP_PSW_WR, 16'h0000, 3'h0);
        op(iak_pkg::IAK_OP_POP_PSW, 16'h0, 3'h0);
        cps(8'h82);
        op(iak_pkg::IAK_OP_DI, 16'h0, 3'h0);
        nmi();
        bnd();
        run(8'h02, 16'h0004, 5);
        cps(8'h00);
        chk({15'h0, nsrv}, 16'h0001);
        nmi();
        nmi();
        bnd();
        run(8'h0, 16'h0, 0);
        op(iak_pkg::IAK_OP_IRQ_RETURN_INSTR, 16'h0, 3'h0);
        cps(8'h02);
        bnd();
        run(8'h0, 16'h0, 0);
        bnd();
        run(8'h02, 16'h0004, 5);
        op(iak_pkg::IAK_OP_IRQ_RETURN_INSTR, 16'h0, 3'h0);
        bnd();
        bnd();
        run(8'h0, 16'h0, 0);
        chk({15'h0, nsrv}, 16'h0000);
        op(iak_pkg::IAK_OP_MSK_WR, 16'h1fd3, 3'h0);
        op(iak_pkg::IAK_OP_PRI_WR, 16'h1fdf, 3'h0);
        chk({3'h0, msk}, 16'h1fd3);
        chk({3'h0, pri}, 16'h1fdf);
        @(negedge clk_i);
        ev = 13'h000c;
        @(negedge clk_i);
        ev = '0;
        bnd();
        run(8'h0, 16'h0, 0);
        cq(16'h000c);
        op(iak_pkg::IAK_OP_EI, 16'h0, 3'h0);
        bnd();
        run(8'h82, 16'h000a, 6);
        cps(8'h02);
        cq(16'h0008);
        op(iak_pkg::IAK_OP_IRQ_RETURN_INSTR, 16'h0, 3'h0);
        cps(8'h82);
        ev = 13'h0020;
        @(negedge clk_i);
        ev = '0;
        bnd();
        run(8'h0, 16'h0, 0);
        bnd();
        run(8'h82, 16'h0010, 5);
        cps(8'h00);
        op(iak_pkg::IAK_OP_EI, 16'h0, 3'h0);
        bnd();
        run(8'h0, 16'h0, 0);
        op(iak_pkg::IAK_OP_IRQ_RETURN_INSTR, 16'h0, 3'h0);
        cps(8'h82);
        bnd();
        bnd();
        run(8'h82, 16'h000c, 6);
        cq(16'h0000);
        op(iak_pkg::IAK_OP_EI, 16'h0, 3'h0);
        op(iak_pkg::IAK_OP_BRK, 16'h0, 3'h0);
        run(8'h82, 16'h003e, 5);
        cps(8'h02);
        op(iak_pkg::IAK_OP_BREAK_RETURN_INSTR, 16'h0, 3'h0);
        cps(8'h82);
        ext_i = 1'b1;
        repeat (24) @(negedge clk_i);
        ext_i = 1'b0;
        repeat (2) @(negedge clk_i);
        cq(16'h0002);
        op(iak_pkg::IAK_OP_REQ_WR, 16'h0, 3'h0);
        ext_i = 1'b1;
        @(negedge clk_i);
        ext_i = 1'b0;
        repeat (24) @(negedge clk_i);
        cq(16'h0000);
        summarize();
    end
endmodule
`default_nettype wire
